/* File: hw/idff_pkg.sv */
// Purpose: constants for the measurement field formatter
// Assumes: 125 MHz clock, 2000 samples/s internal timebase
// Notes:   field widths and modes shared by formatter and fifo users
package idff_pkg;
   localparam int unsigned CLK_HZ          = 125000000;
   localparam int unsigned SAMPLE_RATE_HZ  = 2000;
   localparam int unsigned SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
   localparam int unsigned WORD_W          = 24;
   localparam int unsigned TEMP_W          = 16;
   localparam int unsigned CNT_W           = 8;
   localparam int unsigned BYTE_W          = 8;
   localparam int unsigned NUM_AXES        = 3;
   localparam int unsigned ACC_W           = 40;
   localparam logic [7:0]  CNT_RESET       = 8'h00;
   localparam int unsigned FIFO_DEPTH      = 16;
   localparam int unsigned IV_SCALE_EXP    = 25;
   localparam int unsigned ACC_SCALE_EXP   = 22;
   localparam int unsigned TEMP_SCALE_EXP  = 8;
   localparam int unsigned AUX_SCALE_EXP   = 24;
   typedef enum logic [1:0] {
      IDFF_INC_VEL = 2'b00,
      IDFF_AVG_ACC = 2'b01
   } idff_incl_mode_t;
endpackage

/* File: hw/idff_fifo.sv */
// Purpose: byte fifo between the field formatter and the serial sender
// Assumes: single clock, synchronous active-high reset
// Notes:   read side stalls via out_ready, so the fifo can really fill
`timescale 1ns/1ps
module idff_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             out_valid_reg;
   wire  [AW:0]      count_next;
   wire              do_wr;
   wire              do_rd;
   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = out_valid_reg;
   assign out_data  = mem[rd_ptr_reg];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   assign count_next = count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         out_valid_reg <= 1'b0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg     <= count_next;
         // head flag kept in a flop so the block output has no decode behind it
         out_valid_reg <= (count_next != '0);
      end
   end
endmodule

/* File: hw/idff_formatter.sv */
// Purpose: encode inclinometer, temperature, aux and counter fields as bytes
// Assumes: sensor inputs are synchronous; one sample strobe per timebase tick
// Notes:   averaging divides by the sample count with a sequential divider
`timescale 1ns/1ps
// Contract
// R01: incremental velocity per axis is 24-bit signed, bytes msb, mid, lsb.
// R02: incremental velocity integer over two to the 25 is m/s per sample.
// R03: average mode reports mean of 2000/s samples since last send.
// R04: averaged value is signed 24-bit, integer over two to the 22 is g.
// R05: per-axis temperature is sent only in variants carrying temperature.
// R06: temperature is 16-bit signed, high byte first, over two to the 8.
// R07: aux is 24-bit signed, high byte first, over two to the 24 times 5 V.
// R08: sample counter steps every internal sample, sent or not.
// R09: sample counter is unsigned 8-bit, wraps from 255 to zero.
// R10: counter wrap raises no error or status flag.
// R11: host joins bytes in sent order and sign-extends before scaling.
module idff_formatter #(
   parameter int unsigned SAMPLE_CYC = idff_pkg::SAMPLE_PERIOD_CYC,
   parameter int unsigned FIFO_DEPTH = idff_pkg::FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        incl_mode,
   input  wire logic        temp_enable,
   input  wire logic        aux_enable,
   input  wire logic [71:0] incl_sample,
   input  wire logic [71:0] incl_delta,
   input  wire logic [47:0] temp_sample,
   input  wire logic [23:0] aux_sample,
   input  wire logic        send_req,
   output logic             busy,
   output logic             sample_tick,
   output logic [7:0]       sample_count,
   output logic [7:0]       out_byte,
   output logic             out_valid,
   input  wire logic        out_ready
);
   typedef enum logic [2:0] {
      IDFF_IDLE   = 3'b000,
      IDFF_DIV    = 3'b001,
      IDFF_EMIT   = 3'b010
   } idff_state_t;
   localparam int unsigned TW = $clog2(SAMPLE_CYC);
   localparam int unsigned NB = 22;
   logic [TW-1:0]     tick_cnt_reg;
   logic              tick_reg;
   logic [7:0]        count_reg;
   logic [39:0]       acc_reg [3];
   logic [23:0]       nsamp_reg;
   idff_state_t       state_reg;
   logic              busy_reg;
   logic [7:0]        frame_reg [NB];
   logic [4:0]        nbytes_reg;
   logic [4:0]        idx_reg;
   logic [23:0]       mean_reg [3];
   logic [39:0]       num_reg [3];
   logic [23:0]       den_reg;
   logic [5:0]        div_step_reg;
   logic [39:0]       rem_reg [3];
   wire               tick_now;
   wire               take;
   wire               fifo_ready;
   wire               push;
   wire [7:0]         push_byte;
   assign tick_now = (tick_cnt_reg == TW'(SAMPLE_CYC-1));
   assign take     = send_req & (state_reg == IDFF_IDLE);
   assign push     = (state_reg == IDFF_EMIT) & fifo_ready;
   assign push_byte = frame_reg[idx_reg];
   // busy mirrors state != idle, but as its own flop for a clean port
   assign busy     = busy_reg;
   assign sample_tick  = tick_reg;
   assign sample_count = count_reg;
   // timebase: counter steps on every internal sample, wrap is silent
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
         count_reg    <= idff_pkg::CNT_RESET;
      end else begin
         tick_cnt_reg <= tick_now ? '0 : tick_cnt_reg + 1'b1;
         tick_reg     <= tick_now;
         if (tick_now) begin
            count_reg <= count_reg + 8'h01; // R08 R09 R10
         end
      end
   end
   // accumulators restart on a taken request; a sample in the same cycle starts the new sum
   genvar a;
   generate
      for (a = 0; a < 3; a++) begin : g_axis
         wire signed [23:0] s = incl_sample[a*24 +: 24];
         always_ff @(posedge clk) begin
            if (rst) begin
               acc_reg[a] <= '0;
            end else if (take) begin
               acc_reg[a] <= tick_now ? 40'(s) : '0; // R03
            end else if (tick_now) begin
               acc_reg[a] <= acc_reg[a] + 40'(s); // R03
            end
         end
         // restoring divider on magnitude, sign fixed afterwards
         always_ff @(posedge clk) begin
            if (rst) begin
               num_reg[a]  <= '0;
               rem_reg[a]  <= '0;
               mean_reg[a] <= '0;
            end else if (take) begin
               num_reg[a]  <= acc_reg[a][39] ? 40'(-acc_reg[a]) : acc_reg[a];
               rem_reg[a]  <= '0;
               mean_reg[a] <= {23'h000000, acc_reg[a][39]};
            end else if (state_reg == IDFF_DIV) begin
               num_reg[a] <= {num_reg[a][38:0], 1'b0};
               if ({rem_reg[a][38:0], num_reg[a][39]} >= 40'(den_reg)) begin
                  rem_reg[a] <= {rem_reg[a][38:0], num_reg[a][39]} - 40'(den_reg);
                  num_reg[a][0] <= 1'b1;
               end else begin
                  rem_reg[a] <= {rem_reg[a][38:0], num_reg[a][39]};
               end
            end
         end
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (rst) begin
         nsamp_reg <= '0;
      end else if (take) begin
         nsamp_reg <= tick_now ? 24'h000001 : 24'h000000;
      end else if (tick_now) begin
         nsamp_reg <= nsamp_reg + 24'h000001;
      end
   end
   // frame builder: incl x3, optional temp x3, optional aux, counter
   function automatic logic [23:0] signfix(input logic [39:0] q, input logic neg);
      logic [23:0] m;
      m = q[23:0];
      signfix = neg ? 24'(-m) : m;
   endfunction
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg    <= IDFF_IDLE;
         busy_reg     <= 1'b0;
         nbytes_reg   <= '0;
         idx_reg      <= '0;
         den_reg      <= 24'h000001;
         div_step_reg <= '0;
         for (int i = 0; i < NB; i++) begin
            frame_reg[i] <= 8'h00;
         end
      end else begin
         unique case (state_reg)
            IDFF_IDLE: begin
               if (take) begin
                  den_reg      <= (nsamp_reg == '0) ? 24'h000001 : nsamp_reg;
                  div_step_reg <= '0;
                  idx_reg      <= '0;
                  state_reg    <= IDFF_DIV;
                  busy_reg     <= 1'b1;
               end
            end
            IDFF_DIV: begin
               div_step_reg <= div_step_reg + 6'h01;
               if (div_step_reg == 6'h27) begin
                  for (int i = 0; i < 3; i++) begin
                     logic [23:0] w;
                     w = incl_mode ? signfix({num_reg[i][38:0], 1'b0} |
                         40'(({rem_reg[i][38:0], num_reg[i][39]} >= 40'(den_reg))),
                         mean_reg[i][0]) : incl_delta[i*24 +: 24]; // R01 R02 R03 R04
                     frame_reg[3*i]   <= w[23:16]; // R01
                     frame_reg[3*i+1] <= w[15:8];
                     frame_reg[3*i+2] <= w[7:0];
                  end
                  for (int i = 0; i < 3; i++) begin
                     frame_reg[9+2*i]  <= temp_sample[i*16+8 +: 8]; // R06
                     frame_reg[10+2*i] <= temp_sample[i*16 +: 8];
                  end
                  if (temp_enable) begin // R05
                     frame_reg[15] <= aux_enable ? aux_sample[23:16] : count_reg;
                     frame_reg[16] <= aux_sample[15:8];
                     frame_reg[17] <= aux_sample[7:0];
                     frame_reg[18] <= count_reg;
                     nbytes_reg <= aux_enable ? 5'h13 : 5'h10;
                  end else begin
                     frame_reg[9]  <= aux_enable ? aux_sample[23:16] : count_reg; // R07
                     frame_reg[10] <= aux_sample[15:8];
                     frame_reg[11] <= aux_sample[7:0];
                     frame_reg[12] <= count_reg;
                     nbytes_reg <= aux_enable ? 5'h0d : 5'h0a;
                  end
                  state_reg <= IDFF_EMIT;
               end
            end
            IDFF_EMIT: begin
               if (push) begin
                  idx_reg <= idx_reg + 5'h01;
                  if (idx_reg == nbytes_reg - 5'h01) begin
                     state_reg <= IDFF_IDLE;
                     busy_reg  <= 1'b0;
                  end
               end
            end
            default: state_reg <= IDFF_IDLE;
         endcase
      end
   end
   logic [7:0] fifo_data;
   logic       fifo_valid;
   idff_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (push_byte),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (out_ready)
   );
   assign out_byte  = fifo_data;
   assign out_valid = fifo_valid;
endmodule

/* File: test/idff_props.sv */
// Purpose: port checks for the field formatter
// Assumes: SAMPLE_CYC equals the instance value
// Notes:   first tick after reset is not timed, its phase is free
`timescale 1ns/1ps
module idff_props #(
   parameter int unsigned SAMPLE_CYC = 50
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       send_req,
   input wire logic       busy,
   input wire logic       sample_tick,
   input wire logic [7:0] sample_count,
   input wire logic [7:0] out_byte,
   input wire logic       out_valid,
   input wire logic       out_ready
);
   int unsigned gap_reg;
   logic        seen_reg;
   always_ff @(posedge clk) begin
      gap_reg  <= (rst || sample_tick) ? 0 : gap_reg + 1;
      seen_reg <= rst ? 1'b0 : (seen_reg || sample_tick);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take;
      send_req && !busy;
   endsequence
   sequence s_stall;
      out_valid && !out_ready;
   endsequence
   sequence s_step;
      $changed(sample_count) && !$past(rst);
   endsequence
   a_tick_period: assert property (sample_tick && seen_reg |-> gap_reg == SAMPLE_CYC - 1)
      else $error("tick spacing wrong");
   a_tick_bound: assert property (seen_reg |-> gap_reg < SAMPLE_CYC)
      else $error("tick missing");
   a_tick_pulse: assert property (sample_tick |=> !sample_tick)
      else $error("tick longer than one cycle");
   a_count_step: assert property (s_step |-> sample_count == $past(sample_count) + 8'h01)
      else $error("counter step wrong");
   a_count_tick: assert property (s_step |-> sample_tick || $past(sample_tick))
      else $error("counter moved without tick");
   a_count_wrap: assert property (s_step and $past(sample_count) == 8'hff |-> sample_count == 8'h00)
      else $error("counter wrap wrong");
   a_hold_valid: assert property (s_stall |=> out_valid)
      else $error("byte dropped under stall");
   a_hold_byte: assert property (s_stall |=> $stable(out_byte))
      else $error("byte changed under stall");
   a_busy_take: assert property (s_take |=> busy[*8])
      else $error("request not taken");
endmodule
bind idff_formatter idff_props #(.SAMPLE_CYC(SAMPLE_CYC)) i_idff_props (.clk(clk), .rst(rst),
   .send_req(send_req), .busy(busy), .sample_tick(sample_tick), .sample_count(sample_count),
   .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready));

/* File: test/idff_host_model.sv */
// Purpose: receiving host, collects datagram bytes
// Assumes: stall slows acceptance to one cycle in eight, so a long frame fills the fifo
// Notes:   the bench joins and sign-extends the first three kept bytes
`timescale 1ns/1ps
module idff_host_model (
   input wire logic       clk,
   input wire logic       stall,
   input wire logic [7:0] out_byte,
   input wire logic       out_valid,
   output logic           out_ready
);
   logic [7:0] rx_q[$];
   logic [2:0] ph = 3'h0;
   initial out_ready = 1'b1;
   always @(negedge clk) begin
      ph <= ph + 3'h1;
      out_ready <= !stall || ph == 3'h7;
   end
   always @(posedge clk)
      if (out_valid && out_ready) rx_q.push_back(out_byte);
endmodule

/* File: test/idff_formatter_test.sv */
// Purpose: self-checking bench for the field formatter
// Assumes: short sample period of 50 cycles
// Notes:   constant samples make every average exact
`timescale 1ns/1ps
module idff_formatter_test;
   localparam int unsigned CYC = 50;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        incl_mode = 1'b0;
   logic        temp_enable = 1'b0;
   logic        aux_enable = 1'b0;
   logic [71:0] incl_sample = {24'h123456, 24'hff0001, 24'h80abcd};
   logic [71:0] incl_delta = {24'h7fffff, 24'h800000, 24'hc3a501};
   logic [47:0] temp_sample = {16'hff80, 16'h1900, 16'h8001};
   logic [23:0] aux_sample = 24'ha5c3e1;
   logic        send_req = 1'b0;
   logic        stall = 1'b0;
   logic        busy, sample_tick, out_valid, out_ready;
   logic [7:0]  sample_count, out_byte;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [7:0]  exp_q[$];
   always #4 clk = ~clk;
   idff_formatter #(.SAMPLE_CYC(CYC)) i_idff_formatter (.clk(clk), .rst(rst),
      .incl_mode(incl_mode), .temp_enable(temp_enable), .aux_enable(aux_enable),
      .incl_sample(incl_sample), .incl_delta(incl_delta), .temp_sample(temp_sample),
      .aux_sample(aux_sample), .send_req(send_req), .busy(busy), .sample_tick(sample_tick),
      .sample_count(sample_count), .out_byte(out_byte), .out_valid(out_valid),
      .out_ready(out_ready));
   idff_host_model i_idff_host_model (.clk(clk), .stall(stall), .out_byte(out_byte),
      .out_valid(out_valid), .out_ready(out_ready));
   // cycles since reset release; the counter must follow cyc / CYC on its own
   always @(posedge clk)
      cyc <= rst ? 0 : cyc + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic finish_test();
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // big-endian split, nb bytes of v
   task automatic put(input logic [23:0] v, input int nb);
      for (int i = nb - 1; i >= 0; i--)
         exp_q.push_back(v[8*i+:8]);
   endtask
   // one datagram; a second request inside busy must be ignored
   task automatic run_frame(input bit extra);
      int n;
      logic signed [23:0] w0;
      logic [31:0]        joined;
      exp_q = {};
      i_idff_host_model.rx_q = {};
      for (int a = 0; a < 3; a++)
         put(incl_mode ? incl_sample[24*a+:24] : incl_delta[24*a+:24], 3);
      for (int a = 0; a < 3 && temp_enable; a++)
         put({8'h00, temp_sample[16*a+:16]}, 2);
      if (aux_enable)
         put(aux_sample, 3);
      repeat (60) @(negedge clk);
      send_req = 1'b1;
      @(negedge clk);
      send_req = 1'b0;
      repeat (5) @(negedge clk);
      send_req = extra;
      @(negedge clk);
      send_req = 1'b0;
      // frame is built 40 cycles after the take, counter sampled then
      repeat (33) @(negedge clk);
      exp_q.push_back(8'(cyc / CYC));
      for (n = 0; n < 3000 && i_idff_host_model.rx_q.size() < exp_q.size(); n++)
         @(negedge clk);
      if (n == 3000) begin
         check(32'h0, 32'h1);
         finish_test();
      end
      repeat (80) @(negedge clk);
      check(i_idff_host_model.rx_q.size(), exp_q.size());
      foreach (exp_q[i])
         check(i_idff_host_model.rx_q[i], exp_q[i]);
      w0 = incl_mode ? incl_sample[23:0] : incl_delta[23:0];
      joined = {{8{i_idff_host_model.rx_q[0][7]}}, i_idff_host_model.rx_q[0],
                i_idff_host_model.rx_q[1], i_idff_host_model.rx_q[2]};
      check(joined, 32'(w0));
   endtask
   task automatic sc_formats();
      for (int k = 0; k < 8; k++) begin
         {incl_mode, temp_enable, aux_enable} = k[2:0];
         run_frame(1'b0);
      end
   endtask
   // slow host lets the fifo fill with a 19 byte frame
   task automatic sc_stall();
      stall = 1'b1;
      run_frame(1'b0);
      stall = 1'b0;
   endtask
   task automatic sc_refused();
      run_frame(1'b1);
   endtask
   // long enough to see the counter wrap
   task automatic sc_counter();
      int n;
      for (int t = 0; t < 300; t++) begin
         for (n = 0; n < CYC + 5 && sample_tick !== 1'b1; n++)
            @(negedge clk);
         if (n == CYC + 5) begin
            check(32'h0, 32'h1);
            finish_test();
         end
         repeat (3) @(negedge clk);
         check(sample_count, 8'(cyc / CYC));
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      sc_formats();
      sc_stall();
      sc_refused();
      sc_counter();
      finish_test();
   end
endmodule
